// ### sim/host_model.sv
/* Register master: one-cycle strobes.
   Assumes read data one cycle after the strobe. */
`timescale 1ns/10ps
module host_model
  import irq_pwr_pkg::*;
(
  input  wire logic      clk,           // Clock
  input  wire logic      rdata_valid_q, // Read valid
  input  wire reg_word_t rdata_q,       // Read data
  output logic           wr_en,         // Write strobe
  output logic           rd_en,         // Read strobe
  output reg_addr_t      addr,          // Address
  output reg_word_t      wdata          // Write data
);
  initial {wr_en, rd_en, addr, wdata} = '0;
  task automatic wr(input reg_addr_t a, input reg_word_t d);
    @(posedge clk);
    wr_en <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'h0;
    wdata <= ~d;
  endtask : wr
  task automatic rd(input reg_addr_t a, output reg_word_t d);
    @(posedge clk);
    rd_en <= 1'h1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'h0;
    #1 d = rdata_valid_q ? rdata_q : 'x;
  endtask : rd
endmodule : host_model

// ### sim/irq_ctrl_properties.sv
/* Port assertions for the mask and power control bank.
   Assumes a bind onto the bank top. */
`timescale 1ns/10ps
module irq_ctrl_props
  import irq_pwr_pkg::*;
(
  input wire logic      clk,               // Clock
  input wire logic      arst_n,            // Async reset, active low
  input wire logic      ce,                // Clock enable
  input wire logic      wr_en,             // Write strobe
  input wire logic      rd_en,             // Read strobe
  input wire logic      cfg_wr_req,        // Configuration write request
  input wire logic      adc_busy,          // ADC converting
  input wire reg_addr_t addr,              // Address
  input wire reg_word_t wdata,             // Write data
  input wire reg_word_t int_flags,         // Status flags
  input wire reg_word_t rdata_q,           // Read data
  input wire logic      rdata_valid_q,     // Read data valid
  input wire logic      alert_q,           // Alert request
  input wire logic      dac_power_down_q,  // DAC powered down
  input wire logic      dac_soft_reset_q,  // DAC held in reset
  input wire logic      amps_power_down_q, // Amplifiers forced off
  input wire logic      cfg_reset_q,       // Configuration reset
  input wire logic      cfg_wr_accept_q,   // Configuration write accepted
  input wire logic      adc_abort_q        // ADC abort pulse
);
  reg_word_t mask_q;
  reg_word_t pwr_q;
  logic      alert_exp;
  logic      acc_exp;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  assign alert_exp = |(int_flags & mask_q);
  assign acc_exp   = cfg_wr_req & ~pwr_q[17];
  // Shadow copies of the two registers
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      mask_q <= '0;
    else if (ce && wr_en && addr == 8'h08)
      mask_q <= wdata & 24'h0001DF;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      pwr_q <= '0;
    else if (ce && wr_en && addr == 8'h09)
      pwr_q <= wdata & 24'hAA0000;
  property p_al; ce |=> alert_q == $past(alert_exp); endproperty
  a_al: assert property (p_al) else $error("alert");
  property p_rm; ce && rd_en && addr == 8'h08 |=> rdata_q == $past(mask_q); endproperty
  a_rm: assert property (p_rm) else $error("mask read");
  property p_dp; ce |=> dac_power_down_q == $past(pwr_q[23]); endproperty
  a_dp: assert property (p_dp) else $error("dac down");
  property p_dr; ce |=> dac_soft_reset_q == $past(pwr_q[21]); endproperty
  a_dr: assert property (p_dr) else $error("dac reset");
  property p_ap; ce |=> amps_power_down_q == $past(pwr_q[19]); endproperty
  a_ap: assert property (p_ap) else $error("amps down");
  property p_cr; ce |=> cfg_reset_q == $past(pwr_q[17]); endproperty
  a_cr: assert property (p_cr) else $error("cfg reset");
  property p_ca; ce |=> cfg_wr_accept_q == $past(acc_exp); endproperty
  a_ca: assert property (p_ca) else $error("cfg accept");
  property p_ab; ce && $rose(pwr_q[17]) && adc_busy |=> adc_abort_q; endproperty
  a_ab: assert property (p_ab) else $error("abort");
  property p_ni; ce && !adc_busy |=> !adc_abort_q; endproperty
  a_ni: assert property (p_ni) else $error("abort while idle");
  property p_rp; ce && rd_en && addr == 8'h09 |=> rdata_q == $past(pwr_q); endproperty
  a_rp: assert property (p_rp) else $error("power read");
endmodule : irq_ctrl_props
bind irq_mask_and_power_reset_ctrl irq_ctrl_props u_props (
  .clk               (clk),
  .arst_n            (arst_n),
  .ce                (ce),
  .wr_en             (wr_en),
  .rd_en             (rd_en),
  .cfg_wr_req        (cfg_wr_req),
  .adc_busy          (adc_busy),
  .addr              (addr),
  .wdata             (wdata),
  .int_flags         (int_flags),
  .rdata_q           (rdata_q),
  .rdata_valid_q     (rdata_valid_q),
  .alert_q           (alert_q),
  .dac_power_down_q  (dac_power_down_q),
  .dac_soft_reset_q  (dac_soft_reset_q),
  .amps_power_down_q (amps_power_down_q),
  .cfg_reset_q       (cfg_reset_q),
  .cfg_wr_accept_q   (cfg_wr_accept_q),
  .adc_abort_q       (adc_abort_q)
);

// ### sim/tb.sv
/* Self-checking bench for the control bank.
   Assumes the host model drives the bus. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb
  import irq_pwr_pkg::*;
;
  logic      clk = 1'h0, arst_n = 1'h0, cfg_wr_req = 1'h0, adc_busy = 1'h0;
  logic      wr_en, rd_en, rdata_valid_q, alert_q, dac_power_down_q, dac_soft_reset_q;
  logic      amps_power_down_q, cfg_reset_q, cfg_wr_accept_q, adc_abort_q;
  reg_addr_t addr;
  reg_word_t wdata, rdata_q, v;
  reg_word_t int_flags = '0;
  logic      ce = 1'h1;
  int        failures = 0, checked = 0;
  always #4 clk = ~clk;
  irq_mask_and_power_reset_ctrl dut (
    .clk               (clk),
    .arst_n            (arst_n),
    .ce                (ce),
    .wr_en             (wr_en),
    .rd_en             (rd_en),
    .addr              (addr),
    .wdata             (wdata),
    .int_flags         (int_flags),
    .cfg_wr_req        (cfg_wr_req),
    .adc_busy          (adc_busy),
    .rdata_valid_q     (rdata_valid_q),
    .rdata_q           (rdata_q),
    .alert_q           (alert_q),
    .dac_power_down_q  (dac_power_down_q),
    .dac_soft_reset_q  (dac_soft_reset_q),
    .amps_power_down_q (amps_power_down_q),
    .cfg_reset_q       (cfg_reset_q),
    .cfg_wr_accept_q   (cfg_wr_accept_q),
    .adc_abort_q       (adc_abort_q)
  );
  host_model h (
    .clk           (clk),
    .rdata_valid_q (rdata_valid_q),
    .rdata_q       (rdata_q),
    .wr_en         (wr_en),
    .rd_en         (rd_en),
    .addr          (addr),
    .wdata         (wdata)
  );
  task automatic pulse;
    @(posedge clk) cfg_wr_req <= 1'h1;
    @(posedge clk) cfg_wr_req <= 1'h0;
    #1;
  endtask : pulse
  task automatic t_regs;
    h.rd(8'h08, v);
    `CHK("mask rst", 24'h000000, v)
    h.wr(8'h08, 24'hFFFFFF);
    h.rd(8'h08, v);
    `CHK("mask", 24'h0001DF, v)
    h.wr(8'h09, 24'hFFFFFF);
    h.rd(8'h09, v);
    `CHK("pwr", 24'hAA0000, v)
    `CHK("outs", 4'hF, {dac_power_down_q, dac_soft_reset_q, amps_power_down_q, cfg_reset_q})
    h.wr(8'h09, 24'h000000);
    h.rd(8'h0A, v);
    `CHK("unmapped", 24'h000000, v)
    `CHK("outs off", 4'h0, {dac_power_down_q, dac_soft_reset_q, amps_power_down_q, cfg_reset_q})
  endtask : t_regs
  task automatic t_alert;
    reg_word_t m;
    for (int k = 0; k < 2; k++)
    begin
      m = k ? 24'h000155 : 24'h0000AA;
      h.wr(8'h08, m);
      for (int i = 0; i < 24; i++)
      begin
        @(posedge clk) int_flags <= 24'h000001 << i;
        @(posedge clk) #1;
        `CHK("alert", m[i] && i != 5, alert_q)
      end
    end
    @(posedge clk) int_flags <= '0;
  endtask : t_alert
  task automatic t_freeze;
    h.wr(8'h08, 24'h000001);
    @(posedge clk) ce <= 1'h0;
    h.wr(8'h08, 24'h000000);
    @(posedge clk) int_flags <= 24'h000001;
    @(posedge clk) #1;
    `CHK("frozen alert", 1'h0, alert_q)
    @(posedge clk) ce <= 1'h1;
    @(posedge clk) #1;
    `CHK("resumed alert", 1'h1, alert_q)
    h.rd(8'h08, v);
    `CHK("frozen mask", 24'h000001, v)
    @(posedge clk) int_flags <= '0;
  endtask : t_freeze
  task automatic t_reset;
    h.wr(8'h08, 24'h0001DF);
    h.wr(8'h09, 24'hAA0000);
    @(posedge clk) int_flags <= 24'hFFFFFF;
    @(posedge clk) arst_n <= 1'h0;
    #1;
    `CHK("rst outs", 6'h00, {alert_q, dac_power_down_q, dac_soft_reset_q, amps_power_down_q, cfg_reset_q, rdata_valid_q})
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("alert after rst", 1'h0, alert_q)
    h.rd(8'h08, v);
    `CHK("mask after rst", 24'h000000, v)
    h.rd(8'h09, v);
    `CHK("pwr after rst", 24'h000000, v)
    @(posedge clk) int_flags <= '0;
  endtask : t_reset
  task automatic t_soft;
    @(posedge clk) adc_busy <= 1'h1;
    h.wr(8'h09, 24'h020000);
    @(posedge clk) #1;
    `CHK("abort", 1'h1, adc_abort_q)
    @(posedge clk) #1;
    `CHK("abort pulse", 1'h0, adc_abort_q)
    pulse();
    `CHK("blocked", 1'h0, cfg_wr_accept_q)
    h.wr(8'h09, 24'h080000);
    pulse();
    `CHK("accepted", 1'h1, cfg_wr_accept_q)
    `CHK("amps", 1'h1, amps_power_down_q)
    @(posedge clk) adc_busy <= 1'h0;
    h.wr(8'h09, 24'h020000);
    @(posedge clk) #1;
    `CHK("idle abort", 1'h0, adc_abort_q)
    `CHK("cfg reset", 1'h1, cfg_reset_q)
    `CHK("amps back", 1'h0, amps_power_down_q)
    h.wr(8'h09, 24'h000000);
  endtask : t_soft
  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'h1;
    t_regs();
    t_alert();
    t_freeze();
    t_soft();
    t_reset();
    finish_test();
  end
endmodule : tb

// ### src/ctrl_word_reg.sv
/*
  One 24-bit control word with a write mask; non-writable bits hold the reset
  value, which is zero here. Assumes clk, arst_n and clock enable from the top.
*/
`timescale 1ns/10ps
module ctrl_word_reg
  import irq_pwr_pkg::*;
#(
  parameter reg_word_t RESET_VAL = '0
)(
  input  wire logic  clk,    // Clock
  input  wire logic  arst_n, // Async reset, active low
  input  wire logic  ce,     // Clock enable
  reg_port_if.owner  port    // Write request and read data
);
  reg_word_t word_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      word_q <= RESET_VAL;
    else if (ce && port.we)
      word_q <= (port.wdata & port.wmask) | (RESET_VAL & ~port.wmask);
  end
  assign port.rdata = word_q;
endmodule : ctrl_word_reg

// ### src/irq_mask_and_power_reset_ctrl.sv
/*
  Interrupt mask and power/soft-reset control bank of the analog I/O device,
  written by the serial register interface decoder on the same clock.
  Assumes the decoder presents one-cycle write strobes and reads rdata_q one
  cycle after a read strobe; status flags arrive as synchronous levels.
*/
// Summary of operation
// - A set mask bit lets its source assert the alert pin; a clear bit never does.
// - All mask bits reset to zero.
// - Mask bits 8, 7 and 6 are amp overvoltage, hv and output supply undervoltage.
// - Mask bits 4 to 0 are thermal, overcurrent, config error, CRC and GPIO edge.
// - Power bit 23 powers the DAC down while set; reset value is normal operation.
// - Power bit 21 holds the DAC in reset until written back to zero.
// - Power bit 19 powers down every amplifier regardless of configuration.
// - Clearing bit 19 returns amplifiers to the configured state.
// - Configuration writes are stored while global power-down is set.
// - Power bit 17 resets configuration except CRC enable and reference selects.
// - Setting bit 17 aborts any ADC conversion in progress.
// - Bit 17 never self-clears and blocks configuration writes while set.
// - Each mask bit pairs with the status flag at the same position.
`timescale 1ns/10ps
`include "irq_pwr_map.svh"
module irq_mask_and_power_reset_ctrl
  import irq_pwr_pkg::*;
(
  input  wire logic      clk,                 // Clock, 125 MHz
  input  wire logic      arst_n,              // Async reset, active low
  input  wire logic      ce,                  // Clock enable, freezes state when low
  input  wire logic      wr_en,               // Register write strobe
  input  wire logic      rd_en,               // Register read strobe
  input  wire reg_addr_t addr,                // Register address
  input  wire reg_word_t wdata,               // Write data
  input  wire reg_word_t int_flags,           // Interrupt status flags
  input  wire logic      cfg_wr_req,          // Configuration register write request
  input  wire logic      adc_busy,            // ADC conversion in progress
  output logic           rdata_valid_q,       // Read data valid, one cycle
  output reg_word_t      rdata_q,             // Read data
  output logic           alert_q,             // Alert request, active high
  output logic           dac_power_down_q,    // DAC powered down
  output logic           dac_soft_reset_q,    // DAC held in reset
  output logic           amps_power_down_q,   // All amplifiers forced off
  output logic           cfg_reset_q,         // Configuration reset, keeps CRC/refs
  output logic           cfg_wr_accept_q,     // Configuration write accepted, pulse
  output logic           adc_abort_q          // ADC abort, one-cycle pulse
);
  reg_port_if mask_port ();
  reg_port_if pwr_port ();
  reg_word_t  mask_w;
  reg_word_t  pwr_w;
  reg_word_t  enable_w;
  logic       amp_overvoltage_mask;
  logic       hv_supply_undervolt_mask;
  logic       output_supply_undervolt_mask;
  logic       thermal_warning_mask;
  logic       overcurrent_mask;
  logic       config_error_mask;
  logic       crc_error_mask;
  logic       gpio_edge_mask;
  logic       dac_power_down;
  logic       dac_soft_reset;
  logic       global_power_down;
  logic       global_soft_reset;
  logic       grst_prev_q;

  // Address decode, shared by the write strobes and the read mux
  function automatic logic hit(input reg_addr_t a, input reg_addr_t off);
    hit = (a == off);
  endfunction : hit

  // Read mux; unmapped addresses read zero
  function automatic reg_word_t read_word(
    input reg_addr_t a,
    input reg_word_t mask_word,
    input reg_word_t pwr_word
  );
    if (hit(a, `INTERRUPT_MASK_OFFSET))
      read_word = mask_word;
    else if (hit(a, `POWER_CTRL_OFFSET))
      read_word = pwr_word;
    else
      read_word = '0;
  endfunction : read_word

  // Flags gated bitwise by the enables at the same position
  function automatic logic any_enabled(input reg_word_t flags, input reg_word_t enables);
    any_enabled = |(flags & enables);
  endfunction : any_enabled

  assign mask_port.we    = wr_en && hit(addr, `INTERRUPT_MASK_OFFSET);
  assign mask_port.wdata = wdata;
  assign mask_port.wmask = `INTERRUPT_MASK_WMASK;
  assign pwr_port.we     = wr_en && hit(addr, `POWER_CTRL_OFFSET);
  assign pwr_port.wdata  = wdata;
  assign pwr_port.wmask  = `POWER_CTRL_WMASK;
  assign mask_w = mask_port.rdata;
  assign pwr_w  = pwr_port.rdata;

  ctrl_word_reg #(.RESET_VAL(`INTERRUPT_MASK_RESET)) u_mask (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .port   (mask_port)
  );

  ctrl_word_reg #(.RESET_VAL(`POWER_CTRL_RESET)) u_pwr (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .port   (pwr_port)
  );

  // Named fields of the two control words
  assign amp_overvoltage_mask         = mask_w[`AMP_OVERVOLTAGE_BIT];
  assign hv_supply_undervolt_mask     = mask_w[`HV_SUPPLY_UNDERVOLT_BIT];
  assign output_supply_undervolt_mask = mask_w[`OUTPUT_SUPPLY_UV_BIT];
  assign thermal_warning_mask         = mask_w[`THERMAL_WARNING_BIT];
  assign overcurrent_mask             = mask_w[`OVERCURRENT_BIT];
  assign config_error_mask            = mask_w[`CONFIG_ERROR_BIT];
  assign crc_error_mask               = mask_w[`CRC_ERROR_BIT];
  assign gpio_edge_mask               = mask_w[`GPIO_EDGE_BIT];
  assign dac_power_down               = pwr_w[`DAC_POWER_DOWN_BIT];
  assign dac_soft_reset               = pwr_w[`DAC_SOFT_RESET_BIT];
  assign global_power_down            = pwr_w[`GLOBAL_POWER_DOWN_BIT];
  assign global_soft_reset            = pwr_w[`GLOBAL_SOFT_RESET_BIT];

  // Only documented enables reach the alert; reserved positions stay zero
  always_comb
  begin
    enable_w                               = '0;
    enable_w[`AMP_OVERVOLTAGE_BIT]         = amp_overvoltage_mask;
    enable_w[`HV_SUPPLY_UNDERVOLT_BIT]     = hv_supply_undervolt_mask;
    enable_w[`OUTPUT_SUPPLY_UV_BIT]        = output_supply_undervolt_mask;
    enable_w[`THERMAL_WARNING_BIT]         = thermal_warning_mask;
    enable_w[`OVERCURRENT_BIT]             = overcurrent_mask;
    enable_w[`CONFIG_ERROR_BIT]            = config_error_mask;
    enable_w[`CRC_ERROR_BIT]               = crc_error_mask;
    enable_w[`GPIO_EDGE_BIT]               = gpio_edge_mask;
  end

  // Read data valid, one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_valid_q <= 1'b0;
    else if (ce)
      rdata_valid_q <= rd_en;
  end

  // Read data holds until the next read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_q <= '0;
    else if (ce && rd_en)
      rdata_q <= read_word(addr, mask_w, pwr_w);
  end

  // Alert request
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      alert_q <= 1'b0;
    else if (ce)
      alert_q <= any_enabled(int_flags, enable_w);
  end

  // DAC power-down level
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dac_power_down_q <= 1'b0;
    else if (ce)
      dac_power_down_q <= dac_power_down;
  end

  // DAC held in reset while the bit stays set
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dac_soft_reset_q <= 1'b0;
    else if (ce)
      dac_soft_reset_q <= dac_soft_reset;
  end

  // Amplifier override; clearing hands control back to the configuration
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      amps_power_down_q <= 1'b0;
    else if (ce)
      amps_power_down_q <= global_power_down;
  end

  // Configuration reset level, no self-clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfg_reset_q <= 1'b0;
    else if (ce)
      cfg_reset_q <= global_soft_reset;
  end

  // Configuration writes pass during power-down, blocked during soft reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfg_wr_accept_q <= 1'b0;
    else if (ce)
      cfg_wr_accept_q <= cfg_wr_req && !global_soft_reset;
  end

  // Previous soft reset level; resets to the idle level so no false edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      grst_prev_q <= 1'b0;
    else if (ce)
      grst_prev_q <= global_soft_reset;
  end

  // Abort pulse on rising soft reset while converting
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      adc_abort_q <= 1'b0;
    else if (ce)
      adc_abort_q <= global_soft_reset && !grst_prev_q && adc_busy;
  end
endmodule : irq_mask_and_power_reset_ctrl

// ### src/irq_pwr_map.svh
/*
  Register offsets, field positions and reset values of the interrupt mask and
  power/soft-reset control registers. Assumes inclusion by bare name.
*/
`ifndef IRQ_PWR_MAP_SVH
`define IRQ_PWR_MAP_SVH
`define REG_AW                  8
`define REG_DW                  24
`define INTERRUPT_MASK_OFFSET   8'h08
`define POWER_CTRL_OFFSET       8'h09
`define INTERRUPT_MASK_RESET    24'h000000
`define POWER_CTRL_RESET        24'h000000
`define INTERRUPT_MASK_WMASK    24'h0001DF
`define POWER_CTRL_WMASK        24'hAA0000
`define AMP_OVERVOLTAGE_BIT     8
`define HV_SUPPLY_UNDERVOLT_BIT 7
`define OUTPUT_SUPPLY_UV_BIT    6
`define THERMAL_WARNING_BIT     4
`define OVERCURRENT_BIT         3
`define CONFIG_ERROR_BIT        2
`define CRC_ERROR_BIT           1
`define GPIO_EDGE_BIT           0
`define DAC_POWER_DOWN_BIT      23
`define DAC_SOFT_RESET_BIT      21
`define GLOBAL_POWER_DOWN_BIT   19
`define GLOBAL_SOFT_RESET_BIT   17
`endif

// ### src/irq_pwr_pkg.sv
/*
  Types shared by the interrupt mask / power control bank.
  Assumes the map header for widths.
*/
`include "irq_pwr_map.svh"
package irq_pwr_pkg;
  typedef logic [`REG_DW-1:0] reg_word_t;
  typedef logic [`REG_AW-1:0] reg_addr_t;
endpackage : irq_pwr_pkg

// ### src/reg_port_if.sv
/*
  Register access carrier between the control bank and its storage word.
  Assumes a single clock domain.
*/
`timescale 1ns/10ps
interface reg_port_if;
  import irq_pwr_pkg::*;
  logic      we;
  reg_word_t wdata;
  reg_word_t wmask;
  reg_word_t rdata;
  modport owner (input we, input wdata, input wmask, output rdata);
  modport user  (output we, output wdata, output wmask, input rdata);
endinterface : reg_port_if
